// ==== rtl/ulsf_pkg.sv ====
package ulsf_pkg;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam int LS_FIFO_ERR = 7;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_BREAK = 4;
  localparam int LS_FRAME = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_DATA_READY = 0;
  localparam int CTL_FIFO_MODE = 0;
  localparam int CTL_THRE_IE = 1;
  localparam int IRQ_THRE = 0;
  localparam int IRQ_LINE = 1;
  localparam int IRQ_DATA = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
  localparam int FRAME_CYCLES_DEFAULT = 2170;
endpackage

// ==== rtl/ulsf_brk_if.sv ====
`timescale 1ns/100ps
interface ulsf_brk_if;
  logic rxLine;
  logic [15:0] frameCycles;
  logic breakEvt;
  logic breakActive;
  modport det (input rxLine, input frameCycles, output breakEvt, output breakActive);
  modport usr (output rxLine, output frameCycles, input breakEvt, input breakActive);
endinterface

// ==== rtl/ulsf_break_det.sv ====
`timescale 1ns/100ps
module ulsf_break_det
  import ulsf_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  ulsf_brk_if.det brk
);
  logic [15:0] lowCnt_r;
  logic reported_r;
  logic evt_r;

  // one event per low stretch, however long it lasts
  always_ff @(posedge clock) begin
    if (sys_rst || brk.rxLine) begin
      lowCnt_r <= 16'h0000;
      reported_r <= 1'b0;
      evt_r <= 1'b0;
    end else if (!reported_r && lowCnt_r + 16'h0001 >= brk.frameCycles) begin
      evt_r <= 1'b1; // [R09] [R10]
      reported_r <= 1'b1;
    end else begin
      evt_r <= 1'b0;
      if (!reported_r) begin
        lowCnt_r <= lowCnt_r + 16'h0001;
      end
    end
  end

  assign brk.breakEvt = evt_r;
  assign brk.breakActive = reported_r;

  single_event_a: assert property (@(posedge clock) disable iff (sys_rst)
    evt_r |=> !evt_r) else $error("break event longer than one cycle"); // [R10]
endmodule

// ==== rtl/ulsf_line_status.sv ====
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// R01 - fifo error bit 7 set while any held character has parity, framing or break error
// R02 - reading line status clears the fifo error bit
// R03 - non-fifo: bit 6 high only when holding and shift registers both empty
// R04 - fifo mode: bit 6 high only when transmit fifo and shift register empty
// R05 - non-fifo: bit 5 set when holding character moves into shift register
// R06 - non-fifo: bit 5 cleared when host writes the holding register
// R07 - interrupt request while bit 5 set and its enable is on
// R08 - fifo mode: bit 5 set when fifo empties, cleared once a byte is written
// R09 - bit 4 set when receive line is low for a whole frame time
// R10 - fifo mode: one break character per detected break; a break coinciding with a character shares its push
// R11 - bit 3 set when received character lacks a valid stop bit
// R12 - fifo mode: framing error refers to the character at fifo head
// R13 - bit 2 parity error; fifo mode refers to the character at fifo head
// R14 - bit 1 overrun when character arrives with fifo full; character dropped
// R15 - bit 0 high while a received character is held
// R16 - line status is read-only; error flags read zero after reset
module ulsf_line_status
  import ulsf_pkg::*;
#(
  parameter int ERR_CNT_W = 7
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxPin,
  input wire logic [15:0] frameCycles,
  input wire logic txHoldWrite,
  input wire logic txShiftLoad,
  input wire logic txShiftEmpty,
  input wire logic txFifoEmpty,
  input wire logic rxCharDone,
  input wire logic rxCharPe,
  input wire logic rxCharFe,
  input wire logic rxFifoFull,
  input wire logic rxHeadValid,
  input wire logic rxHeadPe,
  input wire logic rxHeadFe,
  input wire logic rxHeadBi,
  input wire logic rxPop,
  output logic rxFifoPush,
  output logic rxPushPe,
  output logic rxPushFe,
  output logic rxPushBi,
  output logic txEmptyIrq,
  output logic irq
);
  ulsf_brk_if brk ();
  logic rxMeta_r;
  logic rxSync_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] control_r;
  logic [IRQ_BITS-1:0] irqStat_r;
  logic [IRQ_BITS-1:0] irqEn_r;
  logic irq_r;
  logic thre_r;
  logic temt_r;
  logic fifoErr_r;
  logic [ERR_CNT_W-1:0] errCnt_r;
  logic ovr_r;
  logic brkLat_r;
  logic feLat_r;
  logic peLat_r;
  logic push_r;
  logic pushPe_r;
  logic pushFe_r;
  logic pushBi_r;
  logic txIrq_r;
  logic fifoMode;
  logic access;
  logic fire;
  logic lsRead;
  logic mapped;
  logic pushNow;
  logic pushErr;
  logic [7:0] lineStatus;
  logic [IRQ_BITS-1:0] irqEvt;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= rxPin;
      rxSync_r <= rxMeta_r;
    end
  end

  assign brk.rxLine = rxSync_r;
  assign brk.frameCycles = frameCycles;

  ulsf_break_det u_break_det (
    .clock(clock),
    .sys_rst(sys_rst),
    .brk(brk)
  );

  assign fifoMode = control_r[CTL_FIFO_MODE];
  assign access = psel && penable;
  assign fire = access && pready_r;
  assign lsRead = fire && !pwrite && paddr == OFF_LINE_STATUS;
  assign mapped = paddr == OFF_LINE_STATUS || paddr == OFF_IRQ_STATUS || paddr == OFF_IRQ_CLEAR ||
                  paddr == OFF_IRQ_ENABLE || paddr == OFF_CONTROL;

  // a character and a break in the same cycle share one push; the break gets no slot of its own
  assign pushNow = (rxCharDone || brk.breakEvt) && !rxFifoFull; // [R14]
  assign pushErr = rxCharPe || rxCharFe || brk.breakEvt;

  always_comb begin
    lineStatus = 8'h00;
    lineStatus[LS_FIFO_ERR] = fifoErr_r;
    lineStatus[LS_TX_EMPTY] = temt_r;
    lineStatus[LS_THR_EMPTY] = thre_r;
    lineStatus[LS_OVERRUN] = ovr_r;
    lineStatus[LS_DATA_READY] = rxHeadValid; // [R15]
    if (fifoMode) begin
      lineStatus[LS_BREAK] = rxHeadValid && rxHeadBi;
      lineStatus[LS_FRAME] = rxHeadValid && rxHeadFe; // [R12]
      lineStatus[LS_PARITY] = rxHeadValid && rxHeadPe; // [R13]
    end else begin
      lineStatus[LS_BREAK] = brkLat_r;
      lineStatus[LS_FRAME] = feLat_r;
      lineStatus[LS_PARITY] = peLat_r;
    end
  end

  // apb slave: one wait state, then pready with registered data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      if (access && !pready_r && !pwrite) begin
        unique case (paddr)
          OFF_LINE_STATUS: prdata_r <= {24'h00_0000, lineStatus};
          OFF_IRQ_STATUS: prdata_r <= {29'h0, irqStat_r};
          OFF_IRQ_ENABLE: prdata_r <= {29'h0, irqEn_r};
          OFF_CONTROL: prdata_r <= {30'h0, control_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // line status offset has no write path [R16]
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      control_r <= CONTROL_RESET;
      irqEn_r <= IRQ_ENABLE_RESET;
    end else if (fire && pwrite) begin
      if (paddr == OFF_CONTROL) begin
        control_r <= pwdata[1:0];
      end
      if (paddr == OFF_IRQ_ENABLE) begin
        irqEn_r <= pwdata[IRQ_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      thre_r <= 1'b1;
    end else if (fifoMode) begin
      thre_r <= txFifoEmpty && !txHoldWrite; // [R08]
    end else if (txShiftLoad) begin
      thre_r <= 1'b1; // [R05]
    end else if (txHoldWrite) begin
      thre_r <= 1'b0; // [R06]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      temt_r <= 1'b1;
    end else if (fifoMode) begin
      temt_r <= txFifoEmpty && txShiftEmpty && !txHoldWrite; // [R04]
    end else begin
      temt_r <= thre_r && txShiftEmpty && !txHoldWrite; // [R03]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errCnt_r <= '0;
    end else begin
      errCnt_r <= errCnt_r + ERR_CNT_W'(pushNow && pushErr) - ERR_CNT_W'(rxPop && (rxHeadPe || rxHeadFe || rxHeadBi));
    end
  end

  // a new error wins over the clearing read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fifoErr_r <= 1'b0;
    end else if (pushNow && pushErr) begin
      fifoErr_r <= 1'b1; // [R01]
    end else if (lsRead) begin
      fifoErr_r <= 1'b0; // [R02]
    end else if (errCnt_r != '0 && fifoMode) begin
      fifoErr_r <= 1'b1; // [R01]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ovr_r <= 1'b0;
    end else if (rxCharDone && rxFifoFull) begin
      ovr_r <= 1'b1; // [R14]
    end else if (lsRead) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      brkLat_r <= 1'b0;
      feLat_r <= 1'b0;
      peLat_r <= 1'b0;
    end else begin
      brkLat_r <= brk.breakEvt || (brkLat_r && !lsRead); // [R09]
      feLat_r <= (rxCharDone && rxCharFe) || (feLat_r && !lsRead); // [R11]
      peLat_r <= (rxCharDone && rxCharPe) || (peLat_r && !lsRead); // [R13]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      push_r <= 1'b0;
      pushPe_r <= 1'b0;
      pushFe_r <= 1'b0;
      pushBi_r <= 1'b0;
    end else begin
      push_r <= pushNow;
      pushPe_r <= rxCharDone && rxCharPe;
      pushFe_r <= rxCharDone && rxCharFe; // [R11]
      pushBi_r <= brk.breakEvt; // [R10]
    end
  end

  assign irqEvt[IRQ_THRE] = !thre_r && (fifoMode ? txFifoEmpty : txShiftLoad);
  assign irqEvt[IRQ_LINE] = (rxCharDone && (rxFifoFull || pushErr)) || brk.breakEvt;
  assign irqEvt[IRQ_DATA] = pushNow;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStat_r <= '0;
    end else if (fire && pwrite && paddr == OFF_IRQ_CLEAR) begin
      irqStat_r <= irqEvt | (irqStat_r & ~pwdata[IRQ_BITS-1:0]);
    end else begin
      irqStat_r <= irqEvt | irqStat_r;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
      txIrq_r <= 1'b0;
    end else begin
      irq_r <= |(irqStat_r & irqEn_r);
      txIrq_r <= thre_r && control_r[CTL_THRE_IE]; // [R07]
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rxFifoPush = push_r;
  assign rxPushPe = pushPe_r;
  assign rxPushFe = pushFe_r;
  assign rxPushBi = pushBi_r;
  assign txEmptyIrq = txIrq_r;
  assign irq = irq_r;

  sequence lsRead_s;
    lsRead && !(pushNow && pushErr);
  endsequence

  sequence holdWrite_s;
    !fifoMode && txHoldWrite && !txShiftLoad;
  endsequence

  sequence lsCapture_s;
    access && !pready_r && !pwrite && paddr == OFF_LINE_STATUS;
  endsequence

  fifo_err_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    lsRead_s ##1 !(pushNow && pushErr) && !(errCnt_r != '0 && fifoMode) |=> !fifoErr_r)
    else $error("fifo error flag not cleared by status read"); // [R02]
  fifo_err_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    pushNow && pushErr |=> fifoErr_r) else $error("fifo error flag missed"); // [R01]
  thr_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    holdWrite_s |=> !thre_r ##1 !temt_r) else $error("holding empty not cleared by write"); // [R06]
  thr_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    !fifoMode && txShiftLoad |=> thre_r) else $error("holding empty not set on shift load"); // [R05]
  tx_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
    temt_r |-> thre_r || fifoMode) else $error("transmitter empty while holding full"); // [R03]
  fifo_temt_a: assert property (@(posedge clock) disable iff (sys_rst)
    fifoMode && $past(fifoMode) && temt_r |-> $past(txFifoEmpty) && $past(txShiftEmpty))
    else $error("transmitter empty with data in fifo mode"); // [R04]
  fifo_thr_a: assert property (@(posedge clock) disable iff (sys_rst)
    fifoMode && txHoldWrite |=> !thre_r) else $error("fifo holding empty not cleared"); // [R08]
  thre_irq_a: assert property (@(posedge clock) disable iff (sys_rst)
    thre_r && control_r[CTL_THRE_IE] |=> txEmptyIrq) else $error("transmit empty request missing"); // [R07]
  overrun_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    rxCharDone && rxFifoFull |=> ovr_r && !push_r) else $error("overrun not flagged or push leaked"); // [R14]
  head_frame_a: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
    lsCapture_s ##0 fifoMode |=> prdata_r[LS_FRAME] == $past(rxHeadValid && rxHeadFe))
    else $error("frame bit not from head");
  data_ready_a: assert property (@(posedge clock) disable iff (sys_rst) // [R15]
    lsCapture_s |=> prdata_r[LS_DATA_READY] == $past(rxHeadValid))
    else $error("data ready mismatch");
  break_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    brk.breakEvt |=> pushBi_r && brkLat_r) else $error("break not flagged"); // [R09]
  read_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    fire && pwrite && paddr == OFF_LINE_STATUS |=> $stable(control_r) && $stable(irqEn_r))
    else $error("line status write had an effect"); // [R16]
endmodule

// ==== testbench/ulsf_rx_line_model.sv ====
`timescale 1ns/100ps
// serial receive line: idles high, a go pulse holds it low for lowCycles edges
module ulsf_rx_line_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [15:0] lowCycles,
  output logic rxPin
);
  initial begin
    rxPin = 1'b1;
    forever begin
      @(posedge clock);
      if (go === 1'b1) begin
        rxPin <= 1'b0;
        repeat (lowCycles) @(posedge clock);
        rxPin <= 1'b1;
      end
    end
  end
endmodule

// ==== testbench/uart_line_status_flags_tb.sv ====
`timescale 1ns/100ps
module uart_line_status_flags_tb;
  import ulsf_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, txHoldWrite, txShiftLoad, txShiftEmpty, txFifoEmpty, rxCharDone;
  logic rxCharPe, rxCharFe, rxFifoFull, rxHeadValid, rxHeadPe, rxHeadFe, rxHeadBi, rxPop, brkGo;
  logic pready, pslverr, rxPin, rxFifoPush, rxPushPe, rxPushFe, rxPushBi, txEmptyIrq, irq, rdErr, rdSeen;
  logic [2:0] ev;
  logic [7:0] paddr;
  logic [15:0] frameCycles = 16'h0008;
  logic [31:0] pwdata, prdata, rdVal;
  int num_errors = 0;
  int checked = 0;
  int pushes = 0;
  int biPushes = 0;
  int pePushes = 0;
  int fePushes = 0;
  int p;

  always #20 clock = ~clock;
  assign {rxCharDone, txShiftLoad, txHoldWrite} = ev;

  ulsf_line_status i_dut (.*);
  ulsf_rx_line_model i_line (.clock(clock), .go(brkGo), .lowCycles(16'h0028), .rxPin(rxPin));

  always @(posedge clock) begin
    if (rxFifoPush === 1'b1) begin
      pushes++;
      if (rxPushBi === 1'b1) biPushes++;
      if (rxPushPe === 1'b1) pePushes++;
      if (rxPushFe === 1'b1) fePushes++;
    end
  end

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high or 16 cycles have passed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdSeen = (pready === 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (pready_seen(n) == 1'b0) begin
      num_errors++;
      $display("ERROR pready expected 1 seen 0");
      give_verdict();
    end
  endtask

  // the wait loop stops early only when pready was sampled high
  function automatic logic pready_seen(input int cnt);
    return cnt < 16 || rdSeen;
  endfunction

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what,
                    input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdVal & m);
  endtask

  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge clock);
    ev <= 3'h0;
    repeat (2) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clock);
  endtask

  initial begin
    {psel, penable, pwrite, rxCharPe, rxCharFe, rxFifoFull, rxHeadValid, rxHeadPe} = '0;
    {rxHeadFe, rxHeadBi, rxPop, brkGo} = '0;
    {txShiftEmpty, txFifoEmpty} = 2'h3;
    ev = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h60, "reset");
    wr(OFF_LINE_STATUS, 32'hff);
    rd(OFF_LINE_STATUS, 32'h60, "ro");
    wr(OFF_CONTROL, 32'h2);
    chk("txirq on", 32'h1, txEmptyIrq);
    pulse(3'h1);
    rd(OFF_LINE_STATUS, 32'h00, "hold");
    chk("txirq off", 32'h0, txEmptyIrq);
    txShiftEmpty <= 1'b0;
    pulse(3'h2);
    rd(OFF_LINE_STATUS, 32'h20, "load");
    txShiftEmpty <= 1'b1;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h60, "idle");
    for (int i = 0; i < 2; i++) begin
      rxCharPe <= (i == 0);
      rxCharFe <= (i == 1);
      pulse(3'h4);
      rd(OFF_LINE_STATUS, (i == 0) ? 32'he4 : 32'he8, "err");
      rd(OFF_LINE_STATUS, 32'h60, "clr");
    end
    chk("pe push", 32'h1, pePushes);
    chk("fe push", 32'h1, fePushes);
    // interrupt raised, masked, then cleared
    wr(OFF_IRQ_ENABLE, 32'h2);
    chk("irq", 32'h1, irq);
    wr(OFF_IRQ_ENABLE, 32'h0);
    chk("irq masked", 32'h0, irq);
    wr(OFF_IRQ_CLEAR, 32'h2);
    rd(OFF_IRQ_STATUS, 32'h0, "irq clr", 32'h2);
    wr(OFF_IRQ_ENABLE, 32'h2);
    chk("irq cleared", 32'h0, irq);
    {rxCharPe, rxCharFe} <= 2'h0;
    rxFifoFull <= 1'b1;
    p = pushes;
    pulse(3'h4);
    chk("drop", p, pushes);
    rd(OFF_LINE_STATUS, 32'h62, "ovr");
    rxFifoFull <= 1'b0;
    brkGo <= 1'b1;
    @(posedge clock);
    brkGo <= 1'b0;
    repeat (60) @(posedge clock);
    chk("brk chars", 32'h1, biPushes);
    rd(OFF_LINE_STATUS, 32'h90, "brk", 32'h90);
    wr(OFF_CONTROL, 32'h1);
    txFifoEmpty <= 1'b0;
    pulse(3'h1);
    rd(OFF_LINE_STATUS, 32'h00, "fifo tx", 32'h60);
    txFifoEmpty <= 1'b1;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h60, "fifo empty", 32'h60);
    {rxHeadValid, rxHeadFe} <= 2'h3;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h09, "head fe", 32'h0f);
    {rxHeadFe, rxHeadPe} <= 2'h1;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h05, "head pe", 32'h0f);
    {rxHeadValid, rxHeadPe} <= 2'h0;
    @(posedge clock);
    rd(OFF_LINE_STATUS, 32'h00, "no data", 32'h01);
    // three errored entries still sit in the fifo: bit 7 comes back after each read
    rd(OFF_LINE_STATUS, 32'h80, "fifo err held", 32'h80);
    {rxPop, rxHeadBi} <= 2'h3;
    repeat (3) @(posedge clock);
    {rxPop, rxHeadBi} <= 2'h0;
    rd(OFF_LINE_STATUS, 32'h80, "err popped", 32'h80);
    rd(OFF_LINE_STATUS, 32'h00, "err gone", 32'h80);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, rdErr);
    chk("unmapped", 32'h0, rdVal);
    give_verdict();
  end
endmodule
